//--- include/pinfn_pkg.sv
// Shared constants and types for the pin-function, reset and interrupt block.
// Contract
// RQ1: The operating clock is the oscillator clock halved.
// RQ2: Oscillator type is fixed by two build-time options, not by software.
// RQ3: With the three-pin RC option, port B bit 1 belongs to the oscillator.
// RQ4: A low level on the external reset pin returns the device to startup.
// RQ5: A watchdog or illegal-address reset drives the reset pin low.
// RQ6: The interrupt pin feeds an asynchronous interrupt request to the core.
// RQ7: The interrupt fires on falling edges, or on edges and low levels.
// RQ8: With the port option, port A bits 0 to 3 join the interrupt inverted.
// RQ9: The chosen edge or level mode applies to the port pins as well.
// RQ10: After any reset all port A lines are inputs, except in programming.
// RQ11: After any reset port B bit 0 is an input, except in programming.
// RQ12: Port B bit 1 is software-driven and resets to input, with exceptions.
// RQ13: With the pulldown option, each port A pin has a software pulldown.
// RQ14: An option picks an RC startup delay of 4064 or 16 operating cycles.
// RQ15: Interrupt inputs are synchronised, edge-detected and held until acked.
package pinfn_pkg;
	localparam int unsigned STARTUP_LONG_CYCLES  = 4064;
	localparam int unsigned STARTUP_SHORT_CYCLES = 16;
	localparam int unsigned STARTUP_CNT_W        = 12;
	localparam int unsigned PORT_A_W             = 8;
	localparam int unsigned PORT_B_W             = 2;
	localparam int unsigned KEY_W                = 4;
	localparam int unsigned SYNC_DEPTH           = 3;
	localparam logic [1:0]  OSC_CRYSTAL          = 2'h0;
	localparam logic [1:0]  OSC_RC_TWO_PIN       = 2'h1;
	localparam logic [1:0]  OSC_RC_THREE_PIN     = 2'h2;

	typedef enum logic [2:0] {
		ST_RESET   = 3'h1,
		ST_STARTUP = 3'h2,
		ST_RUN     = 3'h4
	} run_state_t;
endpackage : pinfn_pkg

//--- include/irq_req_if.sv
// Interface carrying interrupt sources and the latched request between modules.
`timescale 1ns/100ps
interface irq_req_if;
	logic                            irq_low_sync;
	logic [pinfn_pkg::KEY_W-1:0]     key_high_sync;
	logic                            key_enable;
	logic                            level_mode;
	logic                            req;
	logic                            ack;
	logic                            op_tick;
	modport ctrl (output irq_low_sync, output key_high_sync,
		output key_enable, output level_mode, output ack,
		output op_tick, input req);
	modport det (input irq_low_sync, input key_high_sync,
		input key_enable, input level_mode, input ack,
		input op_tick, output req);
endinterface : irq_req_if

//--- core/irq_detect.sv
// Edge and level detection of the combined external interrupt request.
`timescale 1ns/100ps
module irq_detect (
	input  wire logic clk_sys,
	input  wire logic reset,
	irq_req_if.det    bus
);
	logic active;
	logic active_prev_reg;
	logic req_reg;

	// Port pins join inverted, so a high key looks like a low pin.
	assign active = bus.irq_low_sync
		| (bus.key_enable & (|bus.key_high_sync)); // see RQ8
	assign bus.req = req_reg;

	// Edges are judged on operating-clock ticks so both modes share a timebase.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			active_prev_reg <= 1'b0;
		end else if (bus.op_tick) begin
			active_prev_reg <= active;
		end
	end

	// A new event in the ack cycle wins over the clear.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			req_reg <= 1'b0;
		end else if (bus.op_tick && active && !active_prev_reg) begin
			req_reg <= 1'b1; // see RQ7 RQ9 RQ15
		end else if (bus.op_tick && active && bus.level_mode) begin
			req_reg <= 1'b1; // see RQ7 RQ9
		end else if (bus.ack) begin
			req_reg <= 1'b0; // see RQ15
		end
	end
endmodule : irq_detect

//--- core/pin_function.sv
// Top level: operating clock, reset pin, startup delay, interrupt and ports.
`timescale 1ns/100ps
module pin_function #(
	parameter logic [1:0] OSC_TYPE       = pinfn_pkg::OSC_CRYSTAL,
	parameter bit         LEVEL_MODE     = 1'b1,
	parameter bit         KEY_IRQ_ENABLE = 1'b1,
	parameter bit         PULLDOWN_OPT   = 1'b1,
	parameter bit         SHORT_STARTUP  = 1'b0,
	parameter int unsigned LONG_CYCLES   = pinfn_pkg::STARTUP_LONG_CYCLES
) (
	input  wire logic                           clk_sys,
	input  wire logic                           reset,
	input  wire logic                           reset_pin_n_in,
	output logic                                reset_pin_out,
	output logic                                reset_pin_oe_n,
	input  wire logic                           watchdog_timeout,
	input  wire logic                           illegal_address,
	input  wire logic                           serial_prog_mode,
	output logic                                internal_operating_clock,
	output logic                                op_tick,
	output logic                                core_reset,
	output logic                                core_run,
	input  wire logic                           irq_pin_n,
	input  wire logic [pinfn_pkg::PORT_A_W-1:0] port_a_pins,
	input  wire logic [pinfn_pkg::PORT_A_W-1:0] port_a_dir_sw,
	input  wire logic [pinfn_pkg::PORT_A_W-1:0] port_a_pd_sw,
	input  wire logic [pinfn_pkg::PORT_B_W-1:0] port_b_dir_sw,
	input  wire logic [pinfn_pkg::PORT_A_W-1:0] prog_port_a_dir,
	input  wire logic [pinfn_pkg::PORT_B_W-1:0] prog_port_b_dir,
	input  wire logic                           irq_ack,
	output logic                                irq_request,
	output logic [pinfn_pkg::PORT_A_W-1:0]      port_a_dir,
	output logic [pinfn_pkg::PORT_A_W-1:0]      port_a_pulldown,
	output logic                                port_b_bit0_pin_dir,
	output logic                                port_b_bit1_third_osc_pin_dir,
	output logic                                port_b_bit1_osc_owned
);
	localparam int unsigned CNT_W = pinfn_pkg::STARTUP_CNT_W;
	localparam logic [CNT_W-1:0] LONG_LAST = CNT_W'(LONG_CYCLES - 1);
	localparam logic [CNT_W-1:0] SHORT_LAST =
		CNT_W'(pinfn_pkg::STARTUP_SHORT_CYCLES - 1);
	localparam bit THREE_PIN = (OSC_TYPE == pinfn_pkg::OSC_RC_THREE_PIN);

	pinfn_pkg::run_state_t state_reg;
	pinfn_pkg::run_state_t state_next;
	logic                  div_reg;
	logic [CNT_W-1:0]      count_reg;
	logic                  int_reset_reg;
	logic [pinfn_pkg::SYNC_DEPTH-1:0] rst_sync_reg;
	logic [pinfn_pkg::SYNC_DEPTH-1:0] irq_sync_reg;
	logic [pinfn_pkg::SYNC_DEPTH-1:0] key_sync_reg [pinfn_pkg::KEY_W];
	logic                  rst_low_reg;
	logic                  irq_low_reg;
	logic [pinfn_pkg::KEY_W-1:0] key_high_reg;
	logic                  prog_reg;
	logic [pinfn_pkg::PORT_A_W-1:0] dir_a_reg;
	logic [pinfn_pkg::PORT_A_W-1:0] pd_a_reg;
	logic [pinfn_pkg::PORT_B_W-1:0] dir_b_reg;
	logic                  pin_reset;
	logic [CNT_W-1:0]      startup_last;

	irq_req_if irq_bus ();

	// Oscillator halved into the operating clock; tick marks its rising edge.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			div_reg <= 1'b0;
		end else begin
			div_reg <= ~div_reg; // see RQ1
		end
	end
	assign internal_operating_clock = div_reg;
	assign op_tick = ~div_reg;

	// Three-flop synchronisers; a change counts when stages two and three agree.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rst_sync_reg <= '1;
			irq_sync_reg <= '1;
			rst_low_reg  <= 1'b0;
			irq_low_reg  <= 1'b0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[1:0], reset_pin_n_in};
			irq_sync_reg <= {irq_sync_reg[1:0], irq_pin_n}; // see RQ15
			if (rst_sync_reg[2] == rst_sync_reg[1]) begin
				rst_low_reg <= ~rst_sync_reg[1];
			end
			if (irq_sync_reg[2] == irq_sync_reg[1]) begin
				irq_low_reg <= ~irq_sync_reg[1];
			end
		end
	end

	for (genvar k = 0; k < pinfn_pkg::KEY_W; k++) begin : g_key
		always_ff @(posedge clk_sys or posedge reset) begin
			if (reset) begin
				key_sync_reg[k] <= '0;
				key_high_reg[k] <= 1'b0;
			end else begin
				key_sync_reg[k] <= {key_sync_reg[k][1:0], port_a_pins[k]};
				if (key_sync_reg[k][2] == key_sync_reg[k][1]) begin
					key_high_reg[k] <= key_sync_reg[k][1]; // see RQ15
				end
			end
		end
	end

	// Watchdog or illegal address pulls the reset pin low one cycle later, for as long as it lasts.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			int_reset_reg <= 1'b0;
		end else begin
			int_reset_reg <= watchdog_timeout | illegal_address; // see RQ5
		end
	end
	assign reset_pin_out  = 1'b0;
	assign reset_pin_oe_n = ~int_reset_reg; // see RQ5
	assign pin_reset = rst_low_reg | int_reset_reg; // see RQ4

	// The startup length is a build option, never a software setting.
	assign startup_last = SHORT_STARTUP ? SHORT_LAST : LONG_LAST; // see RQ14

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			pinfn_pkg::ST_RESET: begin
				if (!pin_reset) begin
					state_next = pinfn_pkg::ST_STARTUP;
				end
			end
			pinfn_pkg::ST_STARTUP: begin
				if (pin_reset) begin
					state_next = pinfn_pkg::ST_RESET;
				end else if (op_tick && count_reg == startup_last) begin
					state_next = pinfn_pkg::ST_RUN; // see RQ14
				end
			end
			pinfn_pkg::ST_RUN: begin
				if (pin_reset) begin
					state_next = pinfn_pkg::ST_RESET; // see RQ4
				end
			end
			default: state_next = pinfn_pkg::ST_RESET;
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_reg <= pinfn_pkg::ST_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			count_reg <= '0;
		end else if (state_reg != pinfn_pkg::ST_STARTUP) begin
			count_reg <= '0;
		end else if (op_tick) begin
			count_reg <= count_reg + CNT_W'(1); // see RQ14
		end
	end

	assign core_reset = (state_reg != pinfn_pkg::ST_RUN);
	assign core_run   = (state_reg == pinfn_pkg::ST_RUN);

	// Programming mode is sampled throughout the reset state and held through startup.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			prog_reg <= 1'b0;
		end else if (state_reg == pinfn_pkg::ST_RESET) begin
			prog_reg <= serial_prog_mode;
		end else if (state_reg == pinfn_pkg::ST_RUN) begin
			// Cleared in run so a later reset never starts from a stale mode.
			prog_reg <= 1'b0; // see RQ10 RQ11
		end
	end

	// Directions: inputs or programming control until run, then software control.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			dir_a_reg <= '0;
			dir_b_reg <= '0;
		end else if (state_reg != pinfn_pkg::ST_RUN) begin
			dir_a_reg <= prog_reg ? prog_port_a_dir : '0; // see RQ10
			dir_b_reg <= prog_reg ? prog_port_b_dir : '0; // see RQ11 RQ12
		end else begin
			dir_a_reg <= port_a_dir_sw;
			dir_b_reg <= port_b_dir_sw; // see RQ12
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pd_a_reg <= '0;
		end else if (PULLDOWN_OPT && state_reg == pinfn_pkg::ST_RUN) begin
			pd_a_reg <= port_a_pd_sw & ~port_a_dir_sw; // see RQ13
		end else begin
			pd_a_reg <= '0;
		end
	end

	assign port_a_dir = dir_a_reg;
	assign port_a_pulldown = pd_a_reg;
	assign port_b_bit0_pin_dir = dir_b_reg[0];
	// Under the three-pin RC option the oscillator owns bit 1 outright.
	assign port_b_bit1_third_osc_pin_dir = THREE_PIN ? 1'b0 : dir_b_reg[1]; // see RQ3
	assign port_b_bit1_osc_owned = THREE_PIN; // see RQ2 RQ3

	assign irq_bus.irq_low_sync  = irq_low_reg; // see RQ6
	assign irq_bus.key_high_sync = key_high_reg;
	assign irq_bus.key_enable    = KEY_IRQ_ENABLE; // see RQ8
	assign irq_bus.level_mode    = LEVEL_MODE; // see RQ7 RQ9
	// Holding the clear during reset drops requests latched before startup.
	assign irq_bus.ack           = irq_ack | core_reset; // see RQ4 RQ15
	assign irq_bus.op_tick       = op_tick;
	assign irq_request = irq_bus.req & core_run;

	irq_detect u_irq_detect (
		.clk_sys (clk_sys),
		.reset   (reset),
		.bus     (irq_bus.det)
	);
endmodule : pin_function

//--- verif/board_model.sv
// Board-side model of the reset, interrupt and port A pins.
`timescale 1ns/100ps
module board_model (
	input  wire logic       clk_sys,
	input  wire logic       reset_pin_out,
	input  wire logic       reset_pin_oe_n,
	input  wire logic       button_press,
	input  wire logic       irq_drive,
	input  wire logic [7:0] key_drive,
	input  wire logic [7:0] key_en,
	input  wire logic [7:0] pd_active,
	output logic            reset_pin_n_in,
	output logic            irq_pin_n,
	output logic [7:0]      port_a_pins
);
	logic [7:0] float_reg = 8'h5A;

	// The reset line has a pull-up; the button or the device pulldown wins.
	assign reset_pin_n_in = !(button_press ||
		(!reset_pin_oe_n && !reset_pin_out));
	assign irq_pin_n = !irq_drive;
	// An undriven pin without pulldown toggles, so no stale level passes.
	always @(posedge clk_sys) float_reg <= ~float_reg;
	assign port_a_pins = (key_en & key_drive) |
		(~key_en & ~pd_active & float_reg);
endmodule : board_model

//--- verif/pin_function_props.sv
// Port-level assertions for the pin-function top level.
`timescale 1ns/100ps
module pin_function_props #(
	parameter logic [1:0]  OSC_TYPE       = pinfn_pkg::OSC_CRYSTAL,
	parameter bit          LEVEL_MODE     = 1'b1,
	parameter bit          KEY_IRQ_ENABLE = 1'b1,
	parameter bit          SHORT_STARTUP  = 1'b0,
	parameter int unsigned LONG_CYCLES    = pinfn_pkg::STARTUP_LONG_CYCLES
) (
	input wire logic       clk_sys,
	input wire logic       reset,
	input wire logic       reset_pin_n_in,
	input wire logic       reset_pin_out,
	input wire logic       reset_pin_oe_n,
	input wire logic       watchdog_timeout,
	input wire logic       illegal_address,
	input wire logic       serial_prog_mode,
	input wire logic       internal_operating_clock,
	input wire logic       op_tick,
	input wire logic       core_reset,
	input wire logic       core_run,
	input wire logic       irq_pin_n,
	input wire logic [7:0] port_a_pins,
	input wire logic       irq_ack,
	input wire logic       irq_request,
	input wire logic [7:0] port_a_dir,
	input wire logic [7:0] port_a_pulldown,
	input wire logic       port_b_bit0_pin_dir,
	input wire logic       port_b_bit1_third_osc_pin_dir,
	input wire logic       port_b_bit1_osc_owned
);
	localparam int unsigned NCYC = SHORT_STARTUP ?
		pinfn_pkg::STARTUP_SHORT_CYCLES : LONG_CYCLES;
	int unsigned cnt_reg;

	// Counts reset cycles since the pin last went high, so pin holds do not count.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) cnt_reg <= 0;
		else if (!reset_pin_n_in) cnt_reg <= 0;
		else if (core_reset) cnt_reg <= cnt_reg + 1;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_irq_low;
		(core_run && !irq_ack && !irq_pin_n) [*8];
	endsequence
	sequence s_key_high;
		(core_run && !irq_ack && (|port_a_pins[3:0])) [*8];
	endsequence
	sequence s_quiet_boot;
		(core_reset && irq_pin_n && !(|port_a_pins[3:0])) [*7]
			##1 (core_run && irq_pin_n && !(|port_a_pins[3:0]));
	endsequence

	a_op_clock: assert property (internal_operating_clock |=>
		!internal_operating_clock ##1 internal_operating_clock)
		else $error("operating clock not halved");
	a_tick_phase: assert property (op_tick == !internal_operating_clock)
		else $error("op tick out of phase");
	a_pin_reset: assert property (!reset_pin_n_in [*6] |-> core_reset)
		else $error("reset pin ignored");
	a_fault_pull: assert property ((watchdog_timeout || illegal_address)
		|=> !reset_pin_oe_n && !reset_pin_out) else $error("reset pin not pulled");
	a_fault_core: assert property ((watchdog_timeout || illegal_address)
		|-> ##[1:3] core_reset) else $error("internal reset missing");
	a_irq_level: assert property (s_irq_low |-> irq_request || !LEVEL_MODE)
		else $error("low level request missing");
	a_key_level: assert property (s_key_high |-> irq_request ||
		!(LEVEL_MODE && KEY_IRQ_ENABLE)) else $error("key request missing");
	a_req_hold: assert property (irq_request && !irq_ack |=>
		irq_request || core_reset) else $error("request dropped");
	a_req_gated: assert property (core_reset |-> !irq_request && !core_run)
		else $error("request during reset");
	a_boot_clear: assert property (s_quiet_boot |-> !irq_request)
		else $error("stale request after reset");
	a_ports_input: assert property (core_reset ##1 core_reset &&
		!serial_prog_mode |-> port_a_dir == 8'h00 && !port_b_bit0_pin_dir &&
		!port_b_bit1_third_osc_pin_dir) else $error("pins not inputs");
	a_pd_inputs: assert property ((port_a_pulldown & port_a_dir) == 8'h00)
		else $error("pulldown on output");
	a_osc_owned: assert property (port_b_bit1_osc_owned ==
		(OSC_TYPE == pinfn_pkg::OSC_RC_THREE_PIN) &&
		!(port_b_bit1_osc_owned && port_b_bit1_third_osc_pin_dir))
		else $error("oscillator pin misused");
	a_startup_len: assert property ($fell(core_reset) |->
		cnt_reg >= 2 * NCYC - 2 && cnt_reg <= 2 * NCYC + 8)
		else $error("startup delay wrong");
endmodule : pin_function_props

//--- verif/tb.sv
// Self-checking bench for the pin-function block and its board model.
`timescale 1ns/100ps
bind pin_function pin_function_props #(.OSC_TYPE(OSC_TYPE),
	.LEVEL_MODE(LEVEL_MODE), .KEY_IRQ_ENABLE(KEY_IRQ_ENABLE),
	.SHORT_STARTUP(SHORT_STARTUP), .LONG_CYCLES(LONG_CYCLES)) i_props (.*);
module tb;
	localparam int unsigned N = 20;
	logic       clk_sys = 1'h0, reset = 1'h1, watchdog_timeout = 1'h0;
	logic       illegal_address = 1'h0, serial_prog_mode = 1'h0;
	logic       irq_ack = 1'h0, button = 1'h0, irq_drive = 1'h0;
	logic       reset_pin_n_in, reset_pin_out, reset_pin_oe_n, irq_pin_n;
	logic       internal_operating_clock, op_tick, core_reset, core_run;
	logic       irq_request, port_b_bit0_pin_dir, port_b_bit1_osc_owned;
	logic       port_b_bit1_third_osc_pin_dir;
	logic       edge_req, edge_b1, edge_owned;
	logic [7:0] edge_pd;
	logic [7:0] port_a_dir_sw = 8'h00, port_a_pd_sw = 8'h00, v;
	logic [7:0] key_drive = 8'h00, prog_port_a_dir = 8'h00;
	logic [7:0] port_a_pins, port_a_dir, port_a_pulldown;
	logic [1:0] port_b_dir_sw = 2'h0, prog_port_b_dir = 2'h0;
	int         error_cnt = 0, tests_run = 0, n;

	board_model i_board (.clk_sys(clk_sys), .reset_pin_out(reset_pin_out),
		.reset_pin_oe_n(reset_pin_oe_n), .button_press(button),
		.irq_drive(irq_drive), .key_drive(key_drive), .key_en(8'h0F),
		.pd_active(port_a_pulldown), .reset_pin_n_in(reset_pin_n_in),
		.irq_pin_n(irq_pin_n), .port_a_pins(port_a_pins));
	pin_function #(.OSC_TYPE(pinfn_pkg::OSC_RC_THREE_PIN), .LONG_CYCLES(N))
		i_dut (.*);
	// A second build covers edge-only sensing, no key or pulldown option
	// and the crystal oscillator; the short startup and two-pin RC stay unbuilt.
	pin_function #(.LEVEL_MODE(1'b0), .KEY_IRQ_ENABLE(1'b0),
		.PULLDOWN_OPT(1'b0), .LONG_CYCLES(N)) i_dut_edge (
		.clk_sys(clk_sys),
		.reset(reset),
		.reset_pin_n_in(reset_pin_n_in),
		.reset_pin_out(),
		.reset_pin_oe_n(),
		.watchdog_timeout(watchdog_timeout),
		.illegal_address(illegal_address),
		.serial_prog_mode(serial_prog_mode),
		.internal_operating_clock(),
		.op_tick(),
		.core_reset(),
		.core_run(),
		.irq_pin_n(irq_pin_n),
		.port_a_pins(port_a_pins),
		.port_a_dir_sw(port_a_dir_sw),
		.port_a_pd_sw(port_a_pd_sw),
		.port_b_dir_sw(port_b_dir_sw),
		.prog_port_a_dir(prog_port_a_dir),
		.prog_port_b_dir(prog_port_b_dir),
		.irq_ack(irq_ack),
		.irq_request(edge_req),
		.port_a_dir(),
		.port_a_pulldown(edge_pd),
		.port_b_bit0_pin_dir(),
		.port_b_bit1_third_osc_pin_dir(edge_b1),
		.port_b_bit1_osc_owned(edge_owned));

	initial forever #2 clk_sys = ~clk_sys;

	task automatic cyc(int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask : cyc
	task automatic chk8(string name, logic [7:0] exp, logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk8
	task automatic chk1(string name, logic exp, logic got);
		chk8(name, {7'h00, exp}, {7'h00, got});
	endtask : chk1
	// Bounded so that a design that never leaves reset still ends the run.
	task automatic wait_run();
		for (n = 0; n < 200 && core_run !== 1'h1; n++) cyc(1);
		chk1("run_reached", 1'h1, core_run);
	endtask : wait_run
	task automatic end_test(string name);
		$display("test %s done", name);
	endtask : end_test
	task automatic close_out();
		$display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : close_out

	initial begin
		void'($urandom(56));
		cyc(11);
		chk8("dir_a", 8'h00, port_a_dir);
		chk8("pd_a", 8'h00, port_a_pulldown);
		chk1("dir_b0", 1'h0, port_b_bit0_pin_dir);
		chk1("dir_b1", 1'h0, port_b_bit1_third_osc_pin_dir);
		chk1("owned", 1'h1, port_b_bit1_osc_owned);
		chk1("owned_edge", 1'h0, edge_owned);
		chk1("core_rst", 1'h1, core_reset);
		chk1("pull_idle", 1'h1, reset_pin_oe_n);
		cyc(1);
		reset <= 1'h0;
		wait_run();
		chk1("startup", 1'h1, n >= 2 * N && n <= 2 * N + 4);
		end_test("reset");
		for (int i = 0; i < 6; i++) begin
			v[0] = internal_operating_clock;
			cyc(1);
			chk1("op_clk", ~v[0], internal_operating_clock);
			chk1("op_tick", ~internal_operating_clock, op_tick);
		end
		end_test("clock");
		for (int i = 0; i < 20; i++) begin
			v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
			port_a_dir_sw <= v;
			port_a_pd_sw <= (i < 2) ? 8'hFF : 8'($urandom);
			port_b_dir_sw <= 2'($urandom);
			cyc(2);
			chk8("dir_a", v, port_a_dir);
			chk8("pd_a", port_a_pd_sw & ~v, port_a_pulldown);
			chk1("dir_b0", port_b_dir_sw[0], port_b_bit0_pin_dir);
			chk1("dir_b1", 1'h0, port_b_bit1_third_osc_pin_dir);
			chk1("edge_b1", port_b_dir_sw[1], edge_b1);
			chk8("pd_off", 8'h00, edge_pd);
		end
		end_test("ports");
		for (int s = 0; s < 5; s++) begin
			if (s == 0) irq_drive <= 1'h1;
			else key_drive[s-1] <= 1'h1;
			for (n = 0; n < 20 && irq_request !== 1'h1; n++) cyc(1);
			chk1("irq_set", 1'h1, irq_request);
			chk1("edge_set", s == 0, edge_req);
			irq_ack <= 1'h1;
			cyc(1);
			irq_ack <= 1'h0;
			cyc(6);
			chk1("irq_level", 1'h1, irq_request);
			chk1("edge_level", 1'h0, edge_req);
			irq_drive <= 1'h0;
			key_drive <= 8'($urandom) & 8'hF0;
			cyc(8);
			chk1("irq_hold", 1'h1, irq_request);
			irq_ack <= 1'h1;
			cyc(1);
			irq_ack <= 1'h0;
			cyc(2);
			chk1("irq_clear", 1'h0, irq_request);
		end
		end_test("irq");
		for (int k = 0; k < 2; k++) begin
			port_a_dir_sw <= 8'hFF;
			port_b_dir_sw <= 2'h3;
			cyc(2);
			irq_drive <= 1'h1;
			if (k == 0) watchdog_timeout <= 1'h1;
			else illegal_address <= 1'h1;
			cyc(1);
			watchdog_timeout <= 1'h0;
			illegal_address <= 1'h0;
			chk1("pull_low", 1'h0, reset_pin_oe_n);
			cyc(3);
			chk1("core_rst", 1'h1, core_reset);
			chk8("dir_a", 8'h00, port_a_dir);
			chk1("irq_gate", 1'h0, irq_request);
			irq_drive <= 1'h0;
			wait_run();
			cyc(4);
			chk1("irq_refused", 1'h0, irq_request);
		end
		end_test("internal_reset");
		cyc(2);
		button <= 1'h1;
		cyc(8);
		chk1("pin_rst", 1'h1, core_reset);
		chk8("dir_a", 8'h00, port_a_dir);
		chk1("dir_b0", 1'h0, port_b_bit0_pin_dir);
		button <= 1'h0;
		wait_run();
		chk1("restart", 1'h1, core_run);
		end_test("pin_reset");
		serial_prog_mode <= 1'h1;
		v = 8'($urandom);
		prog_port_a_dir <= v;
		prog_port_b_dir <= 2'h3;
		button <= 1'h1;
		cyc(8);
		chk8("dir_prog", v, port_a_dir);
		chk1("prog_b0", 1'h1, port_b_bit0_pin_dir);
		chk1("prog_b1", 1'h0, port_b_bit1_third_osc_pin_dir);
		chk1("edge_prog_b1", 1'h1, edge_b1);
		button <= 1'h0;
		wait_run();
		serial_prog_mode <= 1'h0;
		end_test("prog_mode");
		close_out();
	end

	initial begin
		#40000;
		error_cnt++;
		close_out();
	end
endmodule : tb
